// ==== src/dic_pkg.sv ====
// Shared constants for the digital input conditioning block
// How it works
// - Enable bit 0 disables an input's special function, 1 activates it.
// - Special-function enable never affects configuration bits 16 to 31.
// - Enable bit 0 is negative limit, bit 1 positive limit, bit 2 home.
// - Home bit comes from input 2 by default; software reroutes it.
// - Inversion 0 reports a high level as 1; inversion 1 reports it as 0.
// - Inversion covers special and normal inputs, not clock and direction.
// - Force enable 1 replaces the pin level with the software value.
// - Force value bit supplies the level of each forced input.
// - Raw word shows sampled levels without inversion, forcing or functions.
// - Range bit 0 selects the 5 V threshold, 1 the 24 V threshold.
// - Differential bit 0 means single-ended input, 1 means differential.
// - A combined status word holds conditioned levels and function states.
// - Lower sixteen configuration bits govern the input levels.
// - Upper sixteen configuration bits govern the output levels.
package dic_pkg;

    // Subindices of the configuration array
    localparam logic [7:0] SUB_HIGHEST   = 8'h00;
    localparam logic [7:0] SUB_SPEC_EN   = 8'h01;
    localparam logic [7:0] SUB_INVERT    = 8'h02;
    localparam logic [7:0] SUB_FORCE_EN  = 8'h03;
    localparam logic [7:0] SUB_FORCE_VAL = 8'h04;
    localparam logic [7:0] SUB_RAW       = 8'h05;
    localparam logic [7:0] SUB_RANGE     = 8'h06;
    localparam logic [7:0] SUB_DIFF      = 8'h07;
    localparam logic [7:0] SUB_ROUTE_EN  = 8'h08;
    localparam logic [7:0] SUB_HOME_SRC  = 8'h10;
    localparam logic [7:0] SUB_STATUS    = 8'h11;

    // Reset values
    localparam logic [7:0]  HIGHEST_VAL  = 8'h08;
    localparam logic [31:0] CFG_RST      = 32'h00000000;
    localparam logic [3:0]  HOME_SRC_RST = 4'h2;

    // Field positions
    localparam int IN_LO        = 0;
    localparam int OUT_LO       = 16;
    localparam int HALF_W       = 16;
    localparam int BIT_NEG_LIM  = 0;
    localparam int BIT_POS_LIM  = 1;
    localparam int BIT_HOME     = 2;
    localparam int NUM_SPEC     = 3;

    // Fixed-index sources of the limit switches
    localparam logic [3:0] NEG_SRC = 4'h0;
    localparam logic [3:0] POS_SRC = 4'h1;

    // Synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 2;

endpackage

// ==== src/dic_sync.sv ====
// Two-stage synchroniser for a bus of independent pin levels
`timescale 1ns/1ps
module dic_sync #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    // First stage is read only by the second stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage_one <= '0;
            sync_out  <= '0;
        end else begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end

endmodule

// ==== src/dic_cond_bit.sv ====
// Per-bit conditioning: force select followed by inversion
`timescale 1ns/1ps
module dic_cond_bit (
    // Sampled level and controls
    input  wire logic raw_level,
    input  wire logic force_en,
    input  wire logic force_val,
    input  wire logic invert,
    input  wire logic no_invert,
    // Conditioned level
    output logic      cond_level
);

    logic selected;

    // Forced value replaces the pin, then polarity is applied
    always_comb begin
        selected   = force_en ? force_val : raw_level;
        cond_level = (invert && !no_invert) ? !selected
                                            : selected;
    end

endmodule

// ==== src/dic_top.sv ====
// Digital input conditioning with its configuration array
`timescale 1ns/1ps
module dic_top #(
    parameter int               INPUTS       = 16,
    parameter int               OUTPUTS      = 16,
    parameter logic [15:0]      CLKDIR_MASK  = 16'h0003
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               sys_rst,
    // Input pins
    input  wire logic [INPUTS-1:0]  in_pin,
    // Clock and direction mode from the motion core
    input  wire logic               clkdir_active,
    // Output levels requested by the motion core
    input  wire logic [OUTPUTS-1:0] out_req,
    // Configuration access port
    input  wire logic [7:0]         cfg_sub,
    input  wire logic               cfg_wr,
    input  wire logic               cfg_rd,
    input  wire logic [31:0]        cfg_wdata,
    output logic      [31:0]        cfg_rdata,
    output logic                    cfg_ack,
    output logic                    cfg_err,
    // Conditioned results
    output logic      [31:0]        input_status,
    output logic                    neg_limit,
    output logic                    pos_limit,
    output logic                    home_switch,
    // Output pins
    output logic      [OUTPUTS-1:0] out_pin,
    // Analogue front-end controls
    output logic      [INPUTS-1:0]  thr_24v,
    output logic      [INPUTS-1:0]  diff_mode
);

    // Configuration words
    logic [31:0] spec_en;
    logic [31:0] invert;
    logic [31:0] force_en;
    logic [31:0] force_val;
    logic [31:0] range_sel;
    logic [31:0] diff_sel;
    logic [31:0] route_en;
    logic [3:0]  home_src;

    // Datapath signals
    logic [INPUTS-1:0] raw_sync;
    logic [INPUTS-1:0] cond;
    logic [INPUTS-1:0] no_inv;
    logic [15:0]       raw_word;
    logic [15:0]       cond_word;
    logic [3:0]        home_index;
    logic              home_level;
    logic              next_neg;
    logic              next_pos;
    logic              next_home;
    logic [31:0]       next_status;
    logic [OUTPUTS-1:0] next_out;
    logic [31:0]       next_rdata;
    logic              sub_valid;
    logic              sub_writable;

    // Pin sampling
    dic_sync #(
        .WIDTH    (INPUTS)
    ) u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in (in_pin),
        .sync_out (raw_sync)
    );

    // Clock and direction inputs keep their polarity
    always_comb begin
        no_inv = '0;
        for (int i = 0; i < INPUTS; i++) begin
            no_inv[i] = clkdir_active && CLKDIR_MASK[i];
        end
    end

    // Per-input conditioning chain
    genvar gi;
    generate
        for (gi = 0; gi < INPUTS; gi++) begin : g_in
            dic_cond_bit u_bit (
                .raw_level  (raw_sync[gi]),
                .force_en   (force_en[dic_pkg::IN_LO + gi]),
                .force_val  (force_val[dic_pkg::IN_LO + gi]),
                .invert     (invert[dic_pkg::IN_LO + gi]),
                .no_invert  (no_inv[gi]),
                .cond_level (cond[gi])
            );
        end
    endgenerate

    // Zero-extended words of sixteen bits
    always_comb begin
        raw_word  = '0;
        cond_word = '0;
        for (int i = 0; i < INPUTS; i++) begin
            raw_word[i]  = raw_sync[i];
            cond_word[i] = cond[i];
        end
    end

    // Home source: fixed input 2 unless routing is enabled
    always_comb begin
        home_index = route_en[dic_pkg::BIT_HOME]
                   ? home_src : dic_pkg::HOME_SRC_RST;
        home_level = cond_word[home_index];   // Absent inputs read as 0
    end

    // Special functions gated by their enable bits
    always_comb begin
        next_neg  = spec_en[dic_pkg::BIT_NEG_LIM] &&
                    cond_word[dic_pkg::NEG_SRC];
        next_pos  = spec_en[dic_pkg::BIT_POS_LIM] &&
                    cond_word[dic_pkg::POS_SRC];
        next_home = spec_en[dic_pkg::BIT_HOME] &&
                    home_level;
    end

    // Combined status: function states low, input levels high
    always_comb begin
        next_status = '0;
        next_status[dic_pkg::BIT_NEG_LIM] = next_neg;
        next_status[dic_pkg::BIT_POS_LIM] = next_pos;
        next_status[dic_pkg::BIT_HOME]    = next_home;
        next_status[dic_pkg::OUT_LO +: dic_pkg::HALF_W] = cond_word;
    end

    // Registered status and function outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            input_status <= '0;
            neg_limit    <= 1'b0;
            pos_limit    <= 1'b0;
            home_switch  <= 1'b0;
        end else begin
            input_status <= next_status;
            neg_limit    <= next_neg;
            pos_limit    <= next_pos;
            home_switch  <= next_home;
        end
    end

    // Output levels controlled by the upper configuration half
    always_comb begin
        next_out = '0;
        for (int j = 0; j < OUTPUTS; j++) begin
            next_out[j] = force_en[dic_pkg::OUT_LO + j]
                        ? force_val[dic_pkg::OUT_LO + j]
                        : out_req[j];
            next_out[j] = next_out[j] ^
                          invert[dic_pkg::OUT_LO + j];
        end
    end

    // Registered output pins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_pin <= '0;
        end else begin
            out_pin <= next_out;
        end
    end

    // Front-end selects registered from the configuration words
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            thr_24v   <= '0;
            diff_mode <= '0;
        end else begin
            thr_24v   <= range_sel[INPUTS-1:0];
            diff_mode <= diff_sel[INPUTS-1:0];
        end
    end

    // Subindex decode
    always_comb begin
        sub_valid    = 1'b1;
        sub_writable = 1'b1;
        unique case (cfg_sub)
            dic_pkg::SUB_HIGHEST:   sub_writable = 1'b0;
            dic_pkg::SUB_SPEC_EN:   sub_writable = 1'b1;
            dic_pkg::SUB_INVERT:    sub_writable = 1'b1;
            dic_pkg::SUB_FORCE_EN:  sub_writable = 1'b1;
            dic_pkg::SUB_FORCE_VAL: sub_writable = 1'b1;
            dic_pkg::SUB_RAW:       sub_writable = 1'b1;
            dic_pkg::SUB_RANGE:     sub_writable = 1'b1;
            dic_pkg::SUB_DIFF:      sub_writable = 1'b1;
            dic_pkg::SUB_ROUTE_EN:  sub_writable = 1'b1;
            dic_pkg::SUB_HOME_SRC:  sub_writable = 1'b1;
            dic_pkg::SUB_STATUS:    sub_writable = 1'b0;
            default: begin
                sub_valid    = 1'b0;
                sub_writable = 1'b0;
            end
        endcase
    end

    // Special-function enable keeps bits 16 to 31 at zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            spec_en <= dic_pkg::CFG_RST;
        end else if (cfg_wr && cfg_sub == dic_pkg::SUB_SPEC_EN) begin
            spec_en <= {{dic_pkg::HALF_W{1'b0}},
                        cfg_wdata[dic_pkg::HALF_W-1:0]};
        end
    end

    // Inversion word
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            invert <= dic_pkg::CFG_RST;
        end else if (cfg_wr && cfg_sub == dic_pkg::SUB_INVERT) begin
            invert <= cfg_wdata;
        end
    end

    // Force enable and force value words
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            force_en  <= dic_pkg::CFG_RST;
            force_val <= dic_pkg::CFG_RST;
        end else begin
            if (cfg_wr && cfg_sub == dic_pkg::SUB_FORCE_EN) begin
                force_en <= cfg_wdata;
            end
            if (cfg_wr && cfg_sub == dic_pkg::SUB_FORCE_VAL) begin
                force_val <= cfg_wdata;
            end
        end
    end

    // Range and differential select words
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            range_sel <= dic_pkg::CFG_RST;
            diff_sel  <= dic_pkg::CFG_RST;
        end else begin
            if (cfg_wr && cfg_sub == dic_pkg::SUB_RANGE) begin
                range_sel <= cfg_wdata;
            end
            if (cfg_wr && cfg_sub == dic_pkg::SUB_DIFF) begin
                diff_sel <= cfg_wdata;
            end
        end
    end

    // Routing enable and home source index
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            route_en <= dic_pkg::CFG_RST;
            home_src <= dic_pkg::HOME_SRC_RST;
        end else begin
            if (cfg_wr && cfg_sub == dic_pkg::SUB_ROUTE_EN) begin
                route_en <= cfg_wdata;
            end
            if (cfg_wr && cfg_sub == dic_pkg::SUB_HOME_SRC) begin
                home_src <= cfg_wdata[3:0];
            end
        end
    end

    // Read multiplexer; the raw word ignores writes
    always_comb begin
        next_rdata = '0;
        unique case (cfg_sub)
            dic_pkg::SUB_HIGHEST:   next_rdata = {24'h000000,
                                                  dic_pkg::HIGHEST_VAL};
            dic_pkg::SUB_SPEC_EN:   next_rdata = spec_en;
            dic_pkg::SUB_INVERT:    next_rdata = invert;
            dic_pkg::SUB_FORCE_EN:  next_rdata = force_en;
            dic_pkg::SUB_FORCE_VAL: next_rdata = force_val;
            dic_pkg::SUB_RAW:       next_rdata = {16'h0000, raw_word};
            dic_pkg::SUB_RANGE:     next_rdata = range_sel;
            dic_pkg::SUB_DIFF:      next_rdata = diff_sel;
            dic_pkg::SUB_ROUTE_EN:  next_rdata = route_en;
            dic_pkg::SUB_HOME_SRC:  next_rdata = {28'h0000000, home_src};
            dic_pkg::SUB_STATUS:    next_rdata = input_status;
            default:                next_rdata = '0;
        endcase
    end

    // Access answer one cycle after the request
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_rdata <= '0;
            cfg_ack   <= 1'b0;
            cfg_err   <= 1'b0;
        end else begin
            cfg_ack <= cfg_wr || cfg_rd;
            if (cfg_wr) begin
                cfg_err <= !sub_writable;
            end else if (cfg_rd) begin
                cfg_err   <= !sub_valid;
                cfg_rdata <= next_rdata;
            end else begin
                cfg_err <= 1'b0;
            end
        end
    end

endmodule

// ==== tb/dic_top_properties.sv ====
// Port assertions for the input conditioning block
`timescale 1ns/1ps
module dic_chk #(
    parameter int INPUTS = 16
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              sys_rst,
    // Watched ports
    input wire logic [INPUTS-1:0] in_pin,
    input wire logic [7:0]        cfg_sub,
    input wire logic              cfg_wr,
    input wire logic              cfg_rd,
    input wire logic [31:0]       cfg_wdata,
    input wire logic [31:0]       cfg_rdata,
    input wire logic              cfg_ack,
    input wire logic [31:0]       input_status,
    input wire logic              neg_limit,
    input wire logic              pos_limit,
    input wire logic              home_switch,
    input wire logic [INPUTS-1:0] thr_24v,
    input wire logic [INPUTS-1:0] diff_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Enable word written, then read back two edges later
    sequence s_en_wr_rd;
        cfg_wr && cfg_sub == 8'h01 ##2 cfg_rd && !cfg_wr && cfg_sub == 8'h01;
    endsequence
    // Pins held steady, then a raw read
    sequence s_raw_rd;
        $stable(in_pin) [*4] ##0 cfg_rd && !cfg_wr && cfg_sub == 8'h05;
    endsequence
    a_upper_clear: assert property (s_en_wr_rd |=>
        cfg_rdata[31:16] == 16'h0000) else $error("enable upper half set");
    a_raw_plain: assert property (s_raw_rd |=>
        cfg_rdata[INPUTS-1:0] == $past(in_pin)) else $error("raw word bad");
    a_ack_next: assert property ((cfg_wr || cfg_rd) |=> cfg_ack)
        else $error("ack missing");
    a_neg_gate: assert property (neg_limit |->
        input_status[16] && input_status[0]) else $error("neg limit bad");
    a_pos_gate: assert property (pos_limit |->
        input_status[17] && input_status[1]) else $error("pos limit bad");
    a_home_flag: assert property (home_switch == input_status[2] &&
        input_status[15:3] == 13'h0000) else $error("status low bad");
    a_range_copy: assert property ((cfg_wr && cfg_sub == 8'h06)
        ##1 !cfg_wr |=> thr_24v == $past(cfg_wdata[INPUTS-1:0], 2))
        else $error("range copy bad");
    a_diff_copy: assert property ((cfg_wr && cfg_sub == 8'h07)
        ##1 !cfg_wr |=> diff_mode == $past(cfg_wdata[INPUTS-1:0], 2))
        else $error("diff copy bad");
endmodule

bind dic_top dic_chk #(.INPUTS(INPUTS)) u_chk (
    .clk(clk), .sys_rst(sys_rst), .in_pin(in_pin), .cfg_sub(cfg_sub),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .input_status(input_status),
    .neg_limit(neg_limit), .pos_limit(pos_limit),
    .home_switch(home_switch), .thr_24v(thr_24v), .diff_mode(diff_mode)
);

// ==== tb/dic_switch_model.sv ====
// Switches and sensors wired to the input pins
`timescale 1ns/1ps
module dic_switch_model #(
    parameter int W = 16
) (
    // Requested contact positions
    input  wire logic [W-1:0] sw_pos,
    // Levels at the pins
    output logic      [W-1:0] in_pin
);
    // Contacts settle a few ns after the request, off the clock edge
    assign #7 in_pin = sw_pos;
endmodule

// ==== tb/dic_top_tb.sv ====
// Self-checking bench for the input conditioning block
`timescale 1ns/1ps
module dic_top_tb;
    // Ordinary case: settings, pins, then expected status and outputs
    typedef struct packed {
        logic [31:0] inv, fen, fval;
        logic [15:0] pin, oreq;
        logic [31:0] st;
        logic [15:0] op;
    } dic_row_t;
    logic        clk = 1'b0, sys_rst = 1'b1, clkdir_active = 1'b0;
    logic        cfg_wr = 1'b0, cfg_rd = 1'b0, e;
    logic [15:0] sw_pos = 16'h0000, out_req = 16'h0000, in_pin;
    logic [7:0]  cfg_sub = 8'h00;
    logic [31:0] cfg_wdata = 32'h00000000, cfg_rdata, input_status, q;
    logic        cfg_ack, cfg_err, neg_limit, pos_limit, home_switch;
    logic [15:0] out_pin, thr_24v, diff_mode;
    int          n_fail = 0, cmp_count = 0, cyc = 0;
    dic_row_t    rows [4];

    // Clock
    always #12.5 clk = ~clk;

    dic_switch_model u_sw (.sw_pos(sw_pos), .in_pin(in_pin));
    dic_top DUT (
        .clk(clk), .sys_rst(sys_rst), .in_pin(in_pin),
        .clkdir_active(clkdir_active), .out_req(out_req),
        .cfg_sub(cfg_sub), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
        .cfg_err(cfg_err), .input_status(input_status),
        .neg_limit(neg_limit), .pos_limit(pos_limit),
        .home_switch(home_switch), .out_pin(out_pin),
        .thr_24v(thr_24v), .diff_mode(diff_mode)
    );

    // Compare a seen value with its expectation
    task automatic check(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // One access: strobe one cycle, answer one cycle later
    task automatic acc(input logic w, input logic [7:0] s,
                       input logic [31:0] d);
        @(negedge clk);
        cfg_wr = w;
        cfg_rd = ~w;
        cfg_sub = s;
        cfg_wdata = d;
        @(negedge clk);
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        check("ack", cfg_ack, 1);
        q = cfg_rdata;
        e = cfg_err;
    endtask
    task automatic wr(input logic [7:0] s, input logic [31:0] d);
        acc(1'b1, s, d);
        check("err", e, 0);
    endtask
    task automatic rd(input logic [7:0] s, input logic [31:0] x);
        acc(1'b0, s, 32'h0);
        check("rdata", q, x);
    endtask
    // Counts and verdict
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Cycle ceiling against hangs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            end_sim;
        end
    end

    // Main sequence
    initial begin
        rows[0] = '{32'h0, 32'h0, 32'h0, 16'h0013, 16'h00FF,
                    32'h00130007, 16'h00FF};
        rows[1] = '{32'h0F00FFFF, 32'h0, 32'h0, 16'h0013, 16'h0000,
                    32'hFFEC0000, 16'h0F00};
        rows[2] = '{32'h0, 32'h00F0000F, 32'h00500005, 16'h00F0, 16'hFFFF,
                    32'h00F50005, 16'hFF5F};
        rows[3] = '{32'h3, 32'h3, 32'h2, 16'h0000, 16'h1234,
                    32'h00010001, 16'h1234};
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 9; i++) begin
            rd(8'(i), (i == 0) ? 32'h8 : 32'h0);
        end
        check("status", input_status, 0);
        // Read-only and unknown places refuse
        acc(1'b1, 8'h00, 32'h55);
        check("ro err", e, 1);
        acc(1'b0, 8'h20, 32'h0);
        check("unk err", e, 1);
        check("unk data", q, 0);
        acc(1'b1, 8'h11, 32'h1);
        check("status ro err", e, 1);
        wr(8'h01, 32'hFFFF0007);
        rd(8'h01, 32'h00000007);
        // Without routing the home bit follows input index 2
        sw_pos = 16'h0004;
        repeat (4) @(negedge clk);
        check("home dflt", input_status, 32'h00040004);
        sw_pos = 16'h0000;
        // Home taken from input 4 instead of the default input 2
        wr(8'h10, 32'h4);
        wr(8'h08, 32'h4);
        rd(8'h10, 32'h00000004);
        wr(8'h05, 32'hFFFFFFFF);
        foreach (rows[i]) begin
            wr(8'h02, rows[i].inv);
            wr(8'h03, rows[i].fen);
            wr(8'h04, rows[i].fval);
            sw_pos = rows[i].pin;
            out_req = rows[i].oreq;
            repeat (4) @(negedge clk);
            check("status", input_status,
                  rows[i].st);
            check("limits", {home_switch, pos_limit, neg_limit},
                  rows[i].st[2:0]);
            check("out", out_pin, rows[i].op);
            rd(8'h05, {16'h0000, rows[i].pin});
            rd(8'h11, rows[i].st);
        end
        // Clock and direction inputs escape inversion
        clkdir_active = 1'b1;
        wr(8'h02, 32'h0000FFFF);
        wr(8'h03, 32'h0);
        sw_pos = 16'h0000;
        repeat (4) @(negedge clk);
        check("clkdir", input_status, 32'hFFFC0004);
        clkdir_active = 1'b0;
        wr(8'h01, 32'h0);
        repeat (3) @(negedge clk);
        check("spec off", input_status, 32'hFFFF0000);
        wr(8'h06, 32'h0000A5C3);
        wr(8'h07, 32'h00003C5A);
        @(negedge clk);
        check("thr", thr_24v, 16'hA5C3);
        check("diff", diff_mode, 16'h3C5A);
        // Reset in mid-run clears the array
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        check("rst status", input_status, 0);
        rd(8'h06, 32'h0);
        end_sim;
    end
endmodule
